/* File: ulpi_status_pkg.sv */
package ulpi_status_pkg;

  // ****************************************************************
  // Command byte layout
  // ****************************************************************
  localparam int unsigned CMD_CODE_HI = 7;
  localparam int unsigned CMD_CODE_LO = 6;
  localparam int unsigned CMD_PAY_HI  = 5;
  localparam int unsigned PID_HI      = 3;

  localparam logic [1:0] CODE_IDLE  = 2'h0;
  localparam logic [1:0] CODE_TX    = 2'h1;
  localparam logic [1:0] CODE_WRITE = 2'h2;
  localparam logic [1:0] CODE_READ  = 2'h3;

  localparam logic [5:0] PAY_NOPID    = 6'h00;
  localparam logic [5:0] PAY_EXTENDED = 6'h2f;
  localparam logic [7:0] BUS_IDLE     = 8'h00;

  // ****************************************************************
  // Status byte fields
  // ****************************************************************
  localparam int unsigned ST_LS_LO  = 0;
  localparam int unsigned ST_VB_LO  = 2;
  localparam int unsigned ST_EV_LO  = 4;
  localparam int unsigned ST_ID_BIT = 6;
  localparam int unsigned ST_ALT    = 7;

  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_01  = 2'h1;
  localparam logic [1:0] LS_10  = 2'h2;

  localparam logic [1:0] VB_BELOW_END = 2'h0;
  localparam logic [1:0] VB_END       = 2'h1;
  localparam logic [1:0] VB_SESS      = 2'h2;
  localparam logic [1:0] VB_A_VALID   = 2'h3;

  localparam logic [1:0] EV_NONE       = 2'h0;
  localparam logic [1:0] EV_ACTIVE     = 2'h1;
  localparam logic [1:0] EV_ERROR      = 2'h3;
  localparam logic [1:0] EV_DISCONNECT = 2'h2;

  localparam logic [1:0] XCVR_HS    = 2'h0;
  localparam logic [1:0] XCVR_LS    = 2'h2;
  localparam logic [1:0] OPMODE_CHIRP = 2'h2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ADDR     = 3'h1,
    ST_WDATA    = 3'h3,
    ST_TXDATA   = 3'h2,
    ST_TURN     = 3'h6,
    ST_RXCMD    = 3'h7,
    ST_RDATA    = 3'h5,
    ST_TURNBACK = 3'h4
  } port_state_t;

endpackage

/* File: pin_sync.sv */
module pin_sync
  import ulpi_status_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ****************************************************************
  // Two stages; the first is read only by the second
  // ****************************************************************
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

/* File: ulpi_command_status_port.sv */
module ulpi_command_status_port
  import ulpi_status_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] ulpi_data_in,
  input  wire logic       ulpi_stp_in,
  output logic      [7:0] ulpi_data_out,
  output logic            ulpi_data_oe_out,
  output logic            ulpi_dir_out,
  output logic            ulpi_nxt_out,
  input  wire logic       dp_in,
  input  wire logic       dm_in,
  input  wire logic       squelch_in,
  input  wire logic       hs_diff_in,
  input  wire logic       id_in,
  input  wire logic       fault_in,
  input  wire logic       sess_end_in,
  input  wire logic       sess_vld_in,
  input  wire logic       a_vbus_vld_in,
  input  wire logic       rx_active_in,
  input  wire logic       rx_error_in,
  input  wire logic       host_disconnect_in,
  input  wire logic       internal_vbus_drive_en_in,
  input  wire logic       external_vbus_drive_en_in,
  input  wire logic       use_external_indicator_in,
  input  wire logic       indicator_passthrough_in,
  input  wire logic       dp_pulldown_in,
  input  wire logic       dm_pulldown_in,
  input  wire logic [1:0] xcvr_select_in,
  input  wire logic       term_select_in,
  input  wire logic [1:0] op_mode_in,
  input  wire logic       bvalid_rise_en_in,
  input  wire logic       bvalid_fall_en_in,
  input  wire logic       low_power_in,
  input  wire logic [7:0] reg_rdata_in,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_write_out,
  output logic            reg_read_out,
  output logic      [3:0] tx_pid_out,
  output logic            tx_start_out,
  output logic            tx_nopid_out,
  output logic      [7:0] tx_data_out,
  output logic            tx_data_valid_out,
  output logic            charge_pump_en_out,
  output logic            power_switch_out_n_out,
  output logic            power_switch_oe_out
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [8:0]  bus_s;
  logic [11:0] line_s;
  logic [7:0]  data_s;
  logic        stp_s;
  logic        dp_s, dm_s, squelch_s, hs_diff_s, id_s, fault_s;
  logic        sess_end_s, sess_vld_s, a_vld_s, rx_act_s, rx_err_s, disc_s;

  pin_sync #(.WIDTH(9)) u_bus_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   ({ulpi_stp_in, ulpi_data_in}),
    .sync_out   (bus_s)
  );

  pin_sync #(.WIDTH(12)) u_line_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   ({dp_in, dm_in, squelch_in, hs_diff_in, id_in, fault_in, sess_end_in,
                  sess_vld_in, a_vbus_vld_in, rx_active_in, rx_error_in, host_disconnect_in}),
    .sync_out   (line_s)
  );

  assign {stp_s, data_s} = bus_s;
  assign {dp_s, dm_s, squelch_s, hs_diff_s, id_s, fault_s, sess_end_s,
          sess_vld_s, a_vld_s, rx_act_s, rx_err_s, disc_s} = line_s;

  // ****************************************************************
  // Status byte assembly
  // ****************************************************************
  logic       host_mode;
  logic       chirp_mode;
  logic       monitored;
  logic       a_valid;
  logic [1:0] line_state;
  logic [1:0] vbus_state;
  logic [1:0] rx_event;
  logic [6:0] status_cur;

  assign host_mode = dp_pulldown_in & dm_pulldown_in;
  assign monitored = use_external_indicator_in & indicator_passthrough_in;

  always_comb
  begin
    chirp_mode = 1'b0;
    if (xcvr_select_in == XCVR_HS)
    begin
      chirp_mode = host_mode ? (op_mode_in == OPMODE_CHIRP) : term_select_in;
    end
  end

  always_comb
  begin
    if (xcvr_select_in == XCVR_HS)
    begin
      if (squelch_s)
      begin
        line_state = LS_SE0;
      end
      else if (chirp_mode)
      begin
        line_state = hs_diff_s ? LS_01 : LS_10;
      end
      else
      begin
        line_state = LS_01;
      end
    end
    else if (host_mode && xcvr_select_in == XCVR_LS)
    begin
      // Low speed flips J and K on the wires, so the code keeps DM, DP order
      line_state = {dm_s, dp_s};
    end
    else
    begin
      line_state = {dm_s, dp_s};
    end
  end

  // With the external indicator but no passthrough, the fault qualifies the internal comparator
  always_comb
  begin
    if (monitored)
    begin
      a_valid = fault_s;
    end
    else if (use_external_indicator_in)
    begin
      a_valid = fault_s & a_vld_s;
    end
    else
    begin
      a_valid = a_vld_s;
    end
  end

  always_comb
  begin
    if (a_valid)
    begin
      vbus_state = VB_A_VALID;
    end
    else if (sess_vld_s)
    begin
      vbus_state = VB_SESS;
    end
    else if (sess_end_s)
    begin
      vbus_state = VB_BELOW_END;
    end
    else
    begin
      vbus_state = VB_END;
    end
  end

  always_comb
  begin
    if (host_mode && disc_s)
    begin
      rx_event = EV_DISCONNECT;
    end
    else if (rx_act_s)
    begin
      rx_event = rx_err_s ? EV_ERROR : EV_ACTIVE;
    end
    else
    begin
      rx_event = EV_NONE;
    end
  end

  assign status_cur = {id_s, rx_event, vbus_state, line_state};

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    port_state_t st;
    logic        is_read;
    logic        nopid;
    logic [7:0]  addr;
    logic        dir;
    logic [1:0]  dir_hist;
    logic        nxt;
    logic        oe;
    logic [7:0]  dout;
    logic [6:0]  last_sent;
    logic        alt_pend;
    logic        bvld_prev;
    logic        reg_write;
    logic        reg_read;
    logic [7:0]  wdata;
    logic [3:0]  pid;
    logic        tx_start;
    logic [7:0]  tx_byte;
    logic        tx_valid;
    logic        cp_en;
    logic        psw_oe;
  } port_reg_t;

  port_reg_t s_q;
  port_reg_t s_d;

  logic       alt_edge;
  logic       status_pend;
  logic       cmd_seen;
  logic [1:0] cmd_code;
  logic [5:0] cmd_pay;

  assign alt_edge = (bvalid_rise_en_in & sess_vld_s & ~s_q.bvld_prev) |
                    (bvalid_fall_en_in & ~sess_vld_s & s_q.bvld_prev);
  // Held off in low power; a status change that reverts before exit never shows, but a latched bvalid edge does
  assign status_pend = ~low_power_in & ((status_cur != s_q.last_sent) | s_q.alt_pend);
  // The bus view is two stages late, so bytes from our own drive window are skipped
  assign cmd_seen    = (data_s != BUS_IDLE) && !s_q.dir_hist[1];
  assign cmd_code    = data_s[CMD_CODE_HI:CMD_CODE_LO];
  assign cmd_pay     = data_s[CMD_PAY_HI:0];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_d           = s_q;
    s_d.nxt       = 1'b0;
    s_d.reg_write = 1'b0;
    s_d.reg_read  = 1'b0;
    s_d.tx_start  = 1'b0;
    s_d.tx_valid  = 1'b0;
    s_d.bvld_prev = sess_vld_s;
    s_d.dir_hist  = {s_q.dir_hist[0], s_q.dir};
    s_d.cp_en     = internal_vbus_drive_en_in & ~external_vbus_drive_en_in;
    s_d.psw_oe    = external_vbus_drive_en_in;
    if (alt_edge)
    begin
      s_d.alt_pend = 1'b1;
    end
    case (s_q.st)
      ST_IDLE:
      begin
        s_d.dir = 1'b0;
        s_d.oe  = 1'b0;
        // Status wins over a new command so that the link sees it first
        if (status_pend)
        begin
          s_d.st      = ST_TURN;
          s_d.dir     = 1'b1;
          s_d.is_read = 1'b0;
        end
        else if (cmd_seen)
        begin
          s_d.nxt = 1'b1;
          case (cmd_code)
            CODE_TX:
            begin
              s_d.st    = ST_TXDATA;
              s_d.nopid = (cmd_pay == PAY_NOPID);
              s_d.pid   = data_s[PID_HI:0];
              s_d.tx_start = (cmd_pay != PAY_NOPID);
            end
            CODE_WRITE:
            begin
              s_d.addr = {2'h0, cmd_pay};
              s_d.st   = (cmd_pay == PAY_EXTENDED) ? ST_ADDR : ST_WDATA;
              s_d.is_read = 1'b0;
            end
            CODE_READ:
            begin
              s_d.addr    = {2'h0, cmd_pay};
              s_d.is_read = 1'b1;
              if (cmd_pay == PAY_EXTENDED)
              begin
                s_d.st = ST_ADDR;
              end
              else
              begin
                s_d.st       = ST_TURN;
                s_d.dir      = 1'b1;
                s_d.nxt      = 1'b0;
                s_d.reg_read = 1'b1;
              end
            end
            default:
            begin
              s_d.nxt = 1'b0;
            end
          endcase
        end
      end
      ST_ADDR:
      begin
        if (status_pend)
        begin
          s_d.st      = ST_TURN;
          s_d.dir     = 1'b1;
          s_d.is_read = 1'b0;
        end
        else
        begin
          s_d.addr = data_s;
          if (s_q.is_read)
          begin
            s_d.st       = ST_TURN;
            s_d.dir      = 1'b1;
            s_d.reg_read = 1'b1;
          end
          else
          begin
            s_d.st  = ST_WDATA;
            s_d.nxt = 1'b1;
          end
        end
      end
      ST_WDATA:
      begin
        if (status_pend)
        begin
          s_d.st  = ST_TURN;
          s_d.dir = 1'b1;
        end
        else
        begin
          s_d.wdata     = data_s;
          s_d.reg_write = 1'b1;
          s_d.st        = ST_IDLE;
        end
      end
      ST_TXDATA:
      begin
        if (stp_s)
        begin
          s_d.st = ST_IDLE;
        end
        else
        begin
          s_d.nxt      = 1'b1;
          s_d.tx_byte  = data_s;
          s_d.tx_valid = 1'b1;
          // No-PID transmit begins with the first data byte taken
          s_d.tx_start = s_q.nopid;
          s_d.nopid    = 1'b0;
        end
      end
      ST_TURN:
      begin
        s_d.oe = 1'b1;
        if (s_q.is_read)
        begin
          s_d.st   = ST_RDATA;
          s_d.dout = reg_rdata_in;
        end
        else
        begin
          s_d.st        = ST_RXCMD;
          s_d.dout      = {s_q.alt_pend, status_cur};
          s_d.last_sent = status_cur;
          s_d.alt_pend  = alt_edge; // Set wins over clear
        end
      end
      ST_RXCMD, ST_RDATA:
      begin
        // More status queued goes out back to back
        if (status_pend && s_q.st == ST_RXCMD)
        begin
          s_d.dout      = {s_q.alt_pend, status_cur};
          s_d.last_sent = status_cur;
          s_d.alt_pend  = alt_edge;
        end
        else
        begin
          s_d.st  = ST_TURNBACK;
          s_d.dir = 1'b0;
          s_d.oe  = 1'b0;
        end
      end
      ST_TURNBACK:
      begin
        s_d.st      = ST_IDLE;
        s_d.is_read = 1'b0;
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_q <= '{st: ST_IDLE, addr: RST_BYTE, dout: RST_BYTE, wdata: RST_BYTE,
               tx_byte: RST_BYTE, last_sent: 7'h00, pid: 4'h0, dir_hist: 2'h0,
               default: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ulpi_data_out          = s_q.dout;
  assign ulpi_data_oe_out       = s_q.oe;
  assign ulpi_dir_out           = s_q.dir;
  assign ulpi_nxt_out           = s_q.nxt;
  assign reg_addr_out           = s_q.addr;
  assign reg_wdata_out          = s_q.wdata;
  assign reg_write_out          = s_q.reg_write;
  assign reg_read_out           = s_q.reg_read;
  assign tx_pid_out             = s_q.pid;
  assign tx_start_out           = s_q.tx_start;
  assign tx_nopid_out           = s_q.nopid;
  assign tx_data_out            = s_q.tx_byte;
  assign tx_data_valid_out      = s_q.tx_valid;
  assign charge_pump_en_out     = s_q.cp_en;
  assign power_switch_out_n_out = 1'b0;
  assign power_switch_oe_out    = s_q.psw_oe;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_read_turn;
    s_q.st == ST_TURN ##1 s_q.st == ST_RDATA ##1 s_q.st == ST_TURNBACK;
  endsequence

  sequence s_nopid_start;
    !tx_start_out ##1 tx_start_out;
  endsequence

  property p_pump_on;
    @(posedge clk_sys_in) disable iff (rst_in)
    internal_vbus_drive_en_in && !external_vbus_drive_en_in |=> charge_pump_en_out;
  endproperty
  a_pump_on: assert property (p_pump_on) else $error("charge pump not enabled");

  property p_ext_switch;
    @(posedge clk_sys_in) disable iff (rst_in)
    external_vbus_drive_en_in |=> power_switch_oe_out && !charge_pump_en_out;
  endproperty
  a_ext_switch: assert property (p_ext_switch) else $error("switch not pulled");

  property p_all_off;
    @(posedge clk_sys_in) disable iff (rst_in)
    !internal_vbus_drive_en_in && !external_vbus_drive_en_in
      |=> !charge_pump_en_out && !power_switch_oe_out;
  endproperty
  a_all_off: assert property (p_all_off) else $error("vbus source left on");

  property p_fault_status;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_q.st == ST_IDLE && !low_power_in && monitored && $changed(fault_s)
      |=> s_q.st == ST_TURN
      ##1 (ulpi_data_out[ST_VB_LO+1:ST_VB_LO] == VB_A_VALID) == $past(fault_s);
  endproperty
  a_fault_status: assert property (p_fault_status) else $error("fault change lost");

  property p_accept;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_q.st == ST_IDLE && !status_pend && cmd_seen && cmd_code != CODE_READ |=> ulpi_nxt_out;
  endproperty
  a_accept: assert property (p_accept) else $error("command not accepted");

  property p_nopid;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_q.st == ST_IDLE && !status_pend && cmd_code == CODE_TX && cmd_pay == PAY_NOPID
      && cmd_seen && !stp_s |=> s_nopid_start;
  endproperty
  a_nopid: assert property (p_nopid) else $error("no-pid start misplaced");

  property p_pid;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_q.st == ST_IDLE && !status_pend && cmd_code == CODE_TX && cmd_pay != PAY_NOPID
      && cmd_seen |=> tx_start_out && tx_pid_out == $past(data_s[PID_HI:0]);
  endproperty
  a_pid: assert property (p_pid) else $error("wrong packet identifier");

  property p_ext_write;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_q.st == ST_IDLE && !status_pend && cmd_code == CODE_WRITE && cmd_pay == PAY_EXTENDED
      && cmd_seen |=> s_q.st == ST_ADDR;
  endproperty
  a_ext_write: assert property (p_ext_write) else $error("extended write missed");

  property p_read;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_q.st == ST_IDLE && !status_pend && cmd_code == CODE_READ && cmd_pay != PAY_EXTENDED
      && cmd_seen |=> s_read_turn;
  endproperty
  a_read: assert property (p_read) else $error("read sequence broken");

  property p_status_drive;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_q.st == ST_RXCMD |-> ulpi_dir_out && ulpi_data_oe_out
      && ulpi_data_out[ST_ID_BIT] == $past(id_s);
  endproperty
  a_status_drive: assert property (p_status_drive) else $error("status byte bad");

  property p_turnaround;
    @(posedge clk_sys_in) disable iff (rst_in)
    $rose(ulpi_dir_out) |-> !ulpi_data_oe_out ##1 ulpi_data_oe_out;
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("no turnaround cycle");

endmodule

/* File: ulpi_link_model.sv */
module ulpi_link_model
  import ulpi_status_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       dir_in,
  input  wire logic       oe_in,
  input  wire logic [7:0] dev_data_in,
  output logic      [7:0] bus_out,
  output logic            stp_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Link side of the byte bus
  // ****
  logic [7:0] drv_q   = BUS_IDLE;
  logic [7:0] st_q    = 8'h00;
  int         st_n    = 0;
  bit         rd_busy = 1'b0;
  initial stp_out = 1'b0;
  // Driven with the inverse of the last byte until the device enables its drive, so a stale byte cannot pass for a good one
  assign bus_out = !dir_in ? drv_q : (oe_in ? dev_data_in : ~drv_q);
  always @(posedge clk_sys_in)
    if (dir_in && oe_in && !rd_busy)
    begin
      st_q <= dev_data_in;
      st_n <= st_n + 1;
    end
  task automatic put(input logic [7:0] b);
    @(negedge clk_sys_in);
    drv_q = b;
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d);
    bit hit;
    hit = 1'b1;
    for (int t = 0; t < 4 && hit; t++)
    begin
      hit = 1'b0;
      while (dir_in)
        @(negedge clk_sys_in);
      put(c);
      if (c[5:0] == PAY_EXTENDED)
        put(a);
      put(d);
      put(BUS_IDLE);
      repeat (6)
      begin
        @(negedge clk_sys_in);
        hit = hit | dir_in;
      end
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] a, output logic [7:0] d);
    rd_busy = 1'b1;
    put(c);
    if (c[5:0] == PAY_EXTENDED)
      put(a);
    put(BUS_IDLE);
    for (int i = 0; i < 12 && !(dir_in && oe_in); i++)
      @(negedge clk_sys_in);
    d = dev_data_in;
    while (dir_in)
      @(negedge clk_sys_in);
    rd_busy = 1'b0;
  endtask
  task automatic tx(input logic [7:0] c, input logic [7:0] b0, input logic [7:0] b1);
    put(c);
    put(b0);
    put(b1);
    put(BUS_IDLE);
    stp_out = 1'b1;
    @(negedge clk_sys_in);
    stp_out = 1'b0;
  endtask
endmodule

/* File: tb_ulpi_command_status_port.sv */
module tb_ulpi_command_status_port
  import ulpi_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] pin = 12'h040;
  logic [13:0] cfg = 14'h0140;
  logic [7:0]  rdata = 8'h5a;
  logic [7:0]  bus, dout, addr, wdata, txd, wa, wd;
  logic [3:0]  pid;
  logic        stp, oe, dir, wr, start, txv, cp, power_switch_out_n, psw_oe, sw;
  logic        nxt, rrd, nopid;
  logic [7:0]  nxt_n = 8'h00, rd_n = 8'h00, np_n = 8'h00;
  logic [7:0]  txq[$];
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [33:0] tv[17] = '{{14'h014c, 12'h042, 8'h02}, {14'h014c, 12'h043, 8'h03},
    {14'h014c, 12'h053, 8'h43}, {14'h014c, 12'h253, 8'h53}, {14'h014c, 12'h653, 8'h73},
    {14'h014c, 12'h613, 8'h77}, {14'h014c, 12'h693, 8'h7b}, {14'h014c, 12'h6b3, 8'h7f},
    {14'h014c, 12'h693, 8'h7b}, {14'h014c, 12'h613, 8'h77}, {14'h094c, 12'h693, 8'hfb},
    {14'h01bc, 12'h091, 8'h49}, {14'h01bc, 12'h891, 8'h69}, {14'h050c, 12'h098, 8'h49},
    {14'h250c, 12'h090, 8'h49}, {14'h250c, 12'h098, 8'h49}, {14'h050c, 12'h098, 8'h49}};
  always #50 clk = ~clk;
  ulpi_link_model lnk (.clk_sys_in(clk), .dir_in(dir), .oe_in(oe), .dev_data_in(dout),
    .bus_out(bus), .stp_out(stp));
  ulpi_command_status_port dut (.clk_sys_in(clk), .rst_in(rst), .ulpi_data_in(bus),
    .ulpi_stp_in(stp), .ulpi_data_out(dout), .ulpi_data_oe_out(oe), .ulpi_dir_out(dir),
    .ulpi_nxt_out(nxt), .dp_in(pin[0]), .dm_in(pin[1]), .squelch_in(pin[2]),
    .hs_diff_in(pin[3]), .id_in(pin[4]), .fault_in(pin[5]), .sess_end_in(pin[6]),
    .sess_vld_in(pin[7]), .a_vbus_vld_in(pin[8]), .rx_active_in(pin[9]),
    .rx_error_in(pin[10]), .host_disconnect_in(pin[11]), .internal_vbus_drive_en_in(cfg[0]),
    .external_vbus_drive_en_in(cfg[1]), .use_external_indicator_in(cfg[2]),
    .indicator_passthrough_in(cfg[3]), .dp_pulldown_in(cfg[4]), .dm_pulldown_in(cfg[5]),
    .xcvr_select_in(cfg[7:6]), .term_select_in(cfg[8]), .op_mode_in(cfg[10:9]),
    .bvalid_rise_en_in(cfg[11]), .bvalid_fall_en_in(cfg[12]), .low_power_in(cfg[13]),
    .reg_rdata_in(rdata), .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_write_out(wr),
    .reg_read_out(rrd), .tx_pid_out(pid), .tx_start_out(start), .tx_nopid_out(nopid),
    .tx_data_out(txd), .tx_data_valid_out(txv), .charge_pump_en_out(cp),
    .power_switch_out_n_out(power_switch_out_n), .power_switch_oe_out(psw_oe));
  // ****
  // Monitors and helpers
  // ****
  always @(posedge clk)
  begin
    if (wr)
      {wa, wd} <= {addr, wdata};
    if (txv)
      txq.push_back(txd);
    if (start)
      sw <= txv;
    nxt_n <= nxt_n + {7'h00, nxt};
    rd_n  <= rd_n + {7'h00, rrd};
    np_n  <= np_n + {7'h00, nopid};
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
      stop_test(1'b1);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [33:0] v);
    int n;
    n = lnk.st_n;
    @(negedge clk);
    {cfg, pin} = v[33:8];
    for (int k = 0; k < 30 && lnk.st_n == n; k++)
      @(negedge clk);
    repeat (6) @(negedge clk);
    chk(lnk.st_q, v[7:0]);
  endtask
  task automatic stop_test(input bit hung);
    if (hung)
      errors++;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial
  begin
    logic [7:0] d;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    for (int i = 0; i < 4; i++)
    begin
      cfg[1:0] = i[1:0];
      repeat (2) @(negedge clk);
      chk({7'h00, cp}, {7'h00, i == 1});
      chk({7'h00, psw_oe}, {7'h00, i[1]});
      chk({7'h00, power_switch_out_n}, 8'h00);
    end
    $display("vbus test done");
    lnk.wr(8'h95, 8'h00, 8'ha5);
    chk(wa, 8'h15);
    chk(wd, 8'ha5);
    chk(nxt_n, 8'h01);
    lnk.wr(8'haf, 8'hc3, 8'h3c);
    chk(wa, 8'hc3);
    chk(wd, 8'h3c);
    chk(nxt_n, 8'h03);
    lnk.rd(8'hc7, 8'h00, d);
    chk(d, 8'h5a);
    chk(addr, 8'h07);
    chk(rd_n, 8'h01);
    rdata = 8'ha6;
    lnk.rd(8'hef, 8'h9e, d);
    chk(d, 8'ha6);
    chk(addr, 8'h9e);
    chk(rd_n, 8'h02);
    chk(nxt_n, 8'h04);
    pin = 12'h041;
    lnk.wr(8'h8a, 8'h00, 8'h77);
    chk(wa, 8'h0a);
    chk(wd, 8'h77);
    chk(lnk.st_q, 8'h01);
    chk(nxt_n, 8'h05);
    $display("register test done");
    lnk.tx(8'h4d, 8'h11, 8'h22);
    repeat (4) @(negedge clk);
    chk({4'h0, pid}, 8'h0d);
    chk(txq[0], 8'h11);
    chk(txq[1], 8'h22);
    chk({7'h00, sw}, 8'h00);
    chk(nxt_n, 8'h08);
    chk(np_n, 8'h00);
    txq.delete();
    lnk.tx(8'h40, 8'h33, 8'h44);
    repeat (4) @(negedge clk);
    chk(txq[0], 8'h33);
    chk({7'h00, sw}, 8'h01);
    chk(nxt_n, 8'h0b);
    chk(np_n, 8'h01);
    $display("transmit test done");
    for (int i = 0; i < 17; i++)
      st(tv[i]);
    $display("status test done");
    stop_test(1'b0);
  end
endmodule
